// ### src/rtbm_map.svh
// Constants for the remote terminal backend memory engine: addresses and timing
`ifndef RTBM_MAP_SVH
`define RTBM_MAP_SVH

// Memory geometry: 2048 words of 16 bits, 64 buffers of 32 words
`define RTBM_ADDR_W        11
`define RTBM_DATA_W        16
`define RTBM_SA_W          5
`define RTBM_WORD_W        5
`define RTBM_HALF_BIT      10

// Special subaddresses inside each half
`define RTBM_SA_RX_STATUS  5'h00
`define RTBM_SA_TX_STATUS  5'h1f
`define RTBM_SA_LOOP       5'h1e

// Clock rate and bus timing figures
`define RTBM_CLK_MHZ       200
`define RTBM_RESP_MIN_NS   4750
`define RTBM_RESP_MAX_NS   7000
`define RTBM_RTRT_TO_NS    57000
`define RTBM_ECHO_MAX_NS   2300

// Cycle counts: least times round up, longest times round down
`define RTBM_RESP_MIN_CYC  ((`RTBM_RESP_MIN_NS * `RTBM_CLK_MHZ + 999) / 1000)
`define RTBM_RESP_MAX_CYC  ((`RTBM_RESP_MAX_NS * `RTBM_CLK_MHZ) / 1000)
`define RTBM_RTRT_TO_CYC   ((`RTBM_RTRT_TO_NS * `RTBM_CLK_MHZ) / 1000)
`define RTBM_ECHO_MAX_CYC  ((`RTBM_ECHO_MAX_NS * `RTBM_CLK_MHZ) / 1000)
`define RTBM_TMR_W         14

`endif

// ### src/rtbm_pkg.sv
// Types shared by the remote terminal backend memory engine
package rtbm_pkg;

  // Kind of memory access shown on the access type pins
  typedef enum logic [1:0] {
    RTBM_ACC_DATA   = 2'b00,
    RTBM_ACC_STATUS = 2'b01,
    RTBM_ACC_CMD    = 2'b10,
    RTBM_ACC_UNUSED = 2'b11
  } rtbm_acc_e;

  // Memory handshake sequencer states
  typedef enum logic [2:0] {
    RTBM_ST_IDLE   = 3'b000,
    RTBM_ST_REQ    = 3'b001,
    RTBM_ST_SETUP  = 3'b010,
    RTBM_ST_STROBE = 3'b011,
    RTBM_ST_HOLD   = 3'b100
  } rtbm_state_e;

  typedef logic [10:0] rtbm_addr_t;
  typedef logic [15:0] rtbm_data_t;
  typedef logic [13:0] rtbm_tmr_t;

endpackage : rtbm_pkg

// ### src/rtbm_map_if.sv
// Carrier between the sequencer and the buffer address mapper
`timescale 1ns/10ps
interface rtbm_map_if;
  import rtbm_pkg::*;

  rtbm_acc_e  acc_type;
  logic       tx;
  logic [4:0] sa;
  logic [4:0] word;
  logic       write;
  logic       loop;
  rtbm_addr_t addr;
  logic       legal;

  // Sequencer asks, mapper answers
  modport seq (output acc_type, tx, sa, word, write, loop, input addr, legal);
  modport map (input acc_type, tx, sa, word, write, loop, output addr, legal);
endinterface : rtbm_map_if

// ### src/rtbm_addr_map.sv
// Buffer address mapper: subaddress and word to memory address, with legality
`timescale 1ns/10ps
`include "rtbm_map.svh"
module rtbm_addr_map
  import rtbm_pkg::*;
(
  // Request and answer
  rtbm_map_if.map m
);

  logic       half;
  logic [4:0] blk;
  logic [4:0] idx;

  // Data goes to the subaddress buffer, status and command words to the status areas
  always_comb
  begin
    half = m.tx;
    blk  = m.sa;
    idx  = m.word;
    if (m.acc_type != RTBM_ACC_DATA)
    begin
      half = 1'b0;
      blk  = m.tx ? `RTBM_SA_TX_STATUS : `RTBM_SA_RX_STATUS;
      idx  = m.sa;
    end
    else if (m.tx && m.loop && (m.sa == `RTBM_SA_LOOP))
    begin
      half = 1'b0;
    end
    m.addr = {half, blk, idx};
  end

  // Writes only to the lower half, reads only from the upper half, except loopback reads
  always_comb
  begin
    if (m.acc_type == RTBM_ACC_UNUSED)
      m.legal = 1'b0;
    else if (m.write)
      m.legal = !half;
    else
      m.legal = half || ((m.acc_type == RTBM_ACC_DATA) && m.tx && m.loop
                         && (m.sa == `RTBM_SA_LOOP));
  end

endmodule : rtbm_addr_map

// ### src/rtbm_bus_timer.sv
// Bus response window, terminal-to-terminal timeout and echo check
`timescale 1ns/10ps
`include "rtbm_map.svh"
module rtbm_bus_timer
  import rtbm_pkg::*;
#(
  parameter int RTRT_CYC = `RTBM_RTRT_TO_CYC
)
(
  // Clock, reset, enable
  input  wire logic i_clk,
  input  wire logic i_rst_n,
  input  wire logic i_ce,
  // Response window
  input  wire logic i_cmd_parity_mid,
  input  wire logic i_status_ready,
  output logic      o_status_go,
  output logic      o_resp_miss,
  // Terminal-to-terminal
  input  wire logic i_rtrt_start,
  input  wire logic i_data_sync,
  output logic      o_rtrt_timeout,
  // Echo check
  input  wire logic i_tx_word_sent,
  input  wire logic [15:0] i_tx_word,
  input  wire logic i_echo_valid,
  input  wire logic [15:0] i_echo_word,
  output logic      o_echo_error
);

  localparam rtbm_tmr_t RESP_MIN = rtbm_tmr_t'(`RTBM_RESP_MIN_CYC);
  localparam rtbm_tmr_t RESP_MAX = rtbm_tmr_t'(`RTBM_RESP_MAX_CYC);
  localparam rtbm_tmr_t ECHO_MAX = rtbm_tmr_t'(`RTBM_ECHO_MAX_CYC);
  localparam rtbm_tmr_t RTRT_MAX = rtbm_tmr_t'(RTRT_CYC);

  typedef struct packed {
    logic       resp_run;
    rtbm_tmr_t  resp_cnt;
    logic       rtrt_run;
    rtbm_tmr_t  rtrt_cnt;
    logic       echo_run;
    rtbm_tmr_t  echo_cnt;
    rtbm_data_t echo_ref;
    logic       status_go;
    logic       resp_miss;
    logic       rtrt_to;
    logic       echo_err;
  } rtbm_tmr_s;

  rtbm_tmr_s q;
  rtbm_tmr_s next_q;

  // Next state of all three timers
  always_comb
  begin
    next_q           = q;
    next_q.status_go = 1'b0;
    next_q.resp_miss = 1'b0;
    next_q.rtrt_to   = 1'b0;
    next_q.echo_err  = 1'b0;
    // Status word may start only inside the response window
    if (i_cmd_parity_mid)
    begin
      next_q.resp_run = 1'b1;
      next_q.resp_cnt = '0;
    end
    else if (q.resp_run)
    begin
      next_q.resp_cnt = q.resp_cnt + 14'h0001;
      if (i_status_ready && (q.resp_cnt >= RESP_MIN - 14'h0001))
      begin
        next_q.status_go = 1'b1;
        next_q.resp_run  = 1'b0;
      end
      else if (q.resp_cnt >= RESP_MAX - 14'h0001)
      begin
        next_q.resp_miss = 1'b1;
        next_q.resp_run  = 1'b0;
      end
    end
    // First data word sync must arrive before the timeout
    if (i_rtrt_start)
    begin
      next_q.rtrt_run = 1'b1;
      next_q.rtrt_cnt = '0;
    end
    else if (q.rtrt_run)
    begin
      next_q.rtrt_cnt = q.rtrt_cnt + 14'h0001;
      if (i_data_sync)
        next_q.rtrt_run = 1'b0;
      else if (q.rtrt_cnt >= RTRT_MAX - 14'h0001)
      begin
        next_q.rtrt_to  = 1'b1;
        next_q.rtrt_run = 1'b0;
      end
    end
    // Every sent word must come back equal and in time
    if (i_tx_word_sent)
    begin
      next_q.echo_run = 1'b1;
      next_q.echo_cnt = '0;
      next_q.echo_ref = i_tx_word;
    end
    else if (q.echo_run)
    begin
      next_q.echo_cnt = q.echo_cnt + 14'h0001;
      if (i_echo_valid)
      begin
        next_q.echo_err = (i_echo_word != q.echo_ref);
        next_q.echo_run = 1'b0;
      end
      else if (q.echo_cnt >= ECHO_MAX - 14'h0001)
      begin
        next_q.echo_err = 1'b1;
        next_q.echo_run = 1'b0;
      end
    end
  end

  // State register
  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
      q <= '0;
    else if (i_ce)
      q <= next_q;
  end

  assign o_status_go    = q.status_go;
  assign o_resp_miss    = q.resp_miss;
  assign o_rtrt_timeout = q.rtrt_to;
  assign o_echo_error   = q.echo_err;

endmodule : rtbm_bus_timer

// ### src/rtbm_backend.sv
// Remote terminal backend memory engine: buffer memory handshake and bus timers
//
// Behaviour
// - Without wait, write strobe is low exactly one clock.
// - Write data and address valid one clock before write strobe falls.
// - Write data and address held one clock after write strobe rises.
// - Without wait, read strobe is low exactly one clock.
// - Read address valid one clock before and after the read strobe.
// - Status word starts 4.75 to 7.0 us after command parity mid-point.
// - Terminal-to-terminal timeout if first data sync misses 57 us.
// - Each sent word's echo is checked; echo returns within 2.3 us.
// - Buffer memory is 2048 words: 64 buffers of 32 words.
// - Receive buffers in lower half, transmit buffers in upper half.
// - Transfer status word goes to subaddress 0 or 31 area.
// - Without loopback, write only lower half, read only upper half.
// - Loopback input forces top address bit low for transmit subaddress 30.
// - Transmit status word for subaddress 30 keeps its normal location.
// - Wait input held low stretches the current strobe.
// - Access type code: 00 data, 01 status word, 10 command.
`timescale 1ns/10ps
`include "rtbm_map.svh"
module rtbm_backend
  import rtbm_pkg::*;
#(
  parameter int RTRT_CYC = `RTBM_RTRT_TO_CYC
)
(
  // Clock, reset, enable
  input  wire logic        i_clk,
  input  wire logic        i_rst_n,
  input  wire logic        i_ce,
  // Access requests from the terminal core
  input  wire logic        i_acc_valid,
  output logic             o_acc_ready,
  input  wire logic        i_acc_write,
  input  wire logic [1:0]  i_acc_type,
  input  wire logic        i_acc_tx,
  input  wire logic [4:0]  i_acc_sa,
  input  wire logic [4:0]  i_acc_word,
  input  wire logic [15:0] i_acc_wdata,
  output logic             o_acc_done,
  output logic             o_acc_error,
  output logic [15:0]      o_acc_rdata,
  // Loopback strap pin
  input  wire logic        i_subaddr_thirty_loopback,
  // Buffer memory bus
  output logic             o_memory_bus_request_n,
  input  wire logic        i_memory_bus_grant_n,
  input  wire logic        i_memory_wait_n,
  output logic             o_memory_write_strobe_n,
  output logic             o_memory_read_strobe_n,
  output logic [1:0]       o_memory_access_type,
  output logic [10:0]      o_mem_addr,
  output logic [15:0]      o_mem_dout,
  output logic             o_mem_dout_en,
  input  wire logic [15:0] i_mem_din,
  // Bus timing events
  input  wire logic        i_cmd_parity_mid,
  input  wire logic        i_status_ready,
  output logic             o_status_go,
  output logic             o_resp_miss,
  input  wire logic        i_rtrt_start,
  input  wire logic        i_data_sync,
  output logic             o_rtrt_timeout,
  input  wire logic        i_tx_word_sent,
  input  wire logic [15:0] i_tx_word,
  input  wire logic        i_echo_valid,
  input  wire logic [15:0] i_echo_word,
  output logic             o_echo_error
);

  typedef struct packed {
    rtbm_state_e st;
    logic        loop_meta;
    logic        loop;
    logic        req_n;
    logic        wr_n;
    logic        rd_n;
    logic        is_write;
    rtbm_acc_e   acc_type;
    rtbm_addr_t  addr;
    rtbm_data_t  dout;
    logic        dout_en;
    rtbm_data_t  rdata;
    logic        done;
    logic        err;
  } rtbm_mem_s;

  localparam rtbm_mem_s RESET_Q = '{
    st:        RTBM_ST_IDLE,
    loop_meta: 1'b0,
    loop:      1'b0,
    req_n:     1'b1,
    wr_n:      1'b1,
    rd_n:      1'b1,
    is_write:  1'b0,
    acc_type:  RTBM_ACC_DATA,
    addr:      '0,
    dout:      '0,
    dout_en:   1'b0,
    rdata:     '0,
    done:      1'b0,
    err:       1'b0
  };

  rtbm_mem_s q;
  rtbm_mem_s next_q;

  rtbm_map_if mif ();

  // Address mapper sees the pending request and the synchronised strap
  assign mif.acc_type = rtbm_acc_e'(i_acc_type);
  assign mif.tx       = i_acc_tx;
  assign mif.sa       = i_acc_sa;
  assign mif.word     = i_acc_word;
  assign mif.write    = i_acc_write;
  assign mif.loop     = q.loop;

  rtbm_addr_map u_map (
    .m (mif.map)
  );

  // Sequencer: request, grant, setup, strobe, hold
  always_comb
  begin
    next_q           = q;
    next_q.loop_meta = i_subaddr_thirty_loopback;
    next_q.loop      = q.loop_meta;
    next_q.done      = 1'b0;
    next_q.err       = 1'b0;
    case (q.st)
      RTBM_ST_IDLE:
      begin
        if (i_acc_valid)
        begin
          if (!mif.legal)
            next_q.err = 1'b1;
          else
          begin
            next_q.addr     = mif.addr;
            next_q.dout     = i_acc_wdata;
            next_q.acc_type = rtbm_acc_e'(i_acc_type);
            next_q.is_write = i_acc_write;
            next_q.req_n    = 1'b0;
            next_q.st       = RTBM_ST_REQ;
          end
        end
      end
      RTBM_ST_REQ:
      begin
        // Request stays low until grant; the arbiter bounds this wait
        if (!i_memory_bus_grant_n)
        begin
          next_q.dout_en = q.is_write;
          next_q.st      = RTBM_ST_SETUP;
        end
      end
      RTBM_ST_SETUP:
      begin
        // Address and data have stood at least one clock with strobes high
        next_q.wr_n = !q.is_write;
        next_q.rd_n = q.is_write;
        next_q.st   = RTBM_ST_STROBE;
      end
      RTBM_ST_STROBE:
      begin
        if (i_memory_wait_n)
        begin
          next_q.wr_n = 1'b1;
          next_q.rd_n = 1'b1;
          if (!q.is_write)
            next_q.rdata = i_mem_din;
          next_q.st = RTBM_ST_HOLD;
        end
        // Wait low keeps the strobe low another clock
        else
          next_q.st = RTBM_ST_STROBE;
      end
      RTBM_ST_HOLD:
      begin
        // Address and data unchanged through this clock
        next_q.req_n   = 1'b1;
        next_q.dout_en = 1'b0;
        next_q.done    = 1'b1;
        next_q.st      = RTBM_ST_IDLE;
      end
      default:
      begin
        next_q = RESET_Q;
      end
    endcase
  end

  // State register
  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
      q <= RESET_Q;
    else if (i_ce)
      q <= next_q;
  end

  // Memory bus and answer outputs, all from the state register
  assign o_acc_ready             = (q.st == RTBM_ST_IDLE);
  assign o_acc_done              = q.done;
  assign o_acc_error             = q.err;
  assign o_acc_rdata             = q.rdata;
  assign o_memory_bus_request_n  = q.req_n;
  assign o_memory_write_strobe_n = q.wr_n;
  assign o_memory_read_strobe_n  = q.rd_n;
  assign o_memory_access_type    = q.acc_type;
  assign o_mem_addr              = q.addr;
  assign o_mem_dout              = q.dout;
  assign o_mem_dout_en           = q.dout_en;

  rtbm_bus_timer #(
    .RTRT_CYC (RTRT_CYC)
  ) u_timer (
    .i_clk            (i_clk),
    .i_rst_n          (i_rst_n),
    .i_ce             (i_ce),
    .i_cmd_parity_mid (i_cmd_parity_mid),
    .i_status_ready   (i_status_ready),
    .o_status_go      (o_status_go),
    .o_resp_miss      (o_resp_miss),
    .i_rtrt_start     (i_rtrt_start),
    .i_data_sync      (i_data_sync),
    .o_rtrt_timeout   (o_rtrt_timeout),
    .i_tx_word_sent   (i_tx_word_sent),
    .i_tx_word        (i_tx_word),
    .i_echo_valid     (i_echo_valid),
    .i_echo_word      (i_echo_word),
    .o_echo_error     (o_echo_error)
  );

endmodule : rtbm_backend

// ### verification/rtbm_assertions.sv
// Handshake and address checks on the backend buffer memory bus
`timescale 1ns/10ps
module rtbm_checker
  import rtbm_pkg::*;
#(
  parameter int RTRT_CYC = 40
)
(
  // Clock, reset, enable
  input wire logic        i_clk,
  input wire logic        i_rst_n,
  input wire logic        i_ce,
  // Memory bus
  input wire logic        i_memory_bus_grant_n,
  input wire logic        i_memory_wait_n,
  input wire logic        o_memory_bus_request_n,
  input wire logic        o_memory_write_strobe_n,
  input wire logic        o_memory_read_strobe_n,
  input wire logic [1:0]  o_memory_access_type,
  input wire logic [10:0] o_mem_addr,
  input wire logic [15:0] o_mem_dout,
  input wire logic        o_mem_dout_en
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  logic wr;
  logic rd;
  // Strobes taken active high for readability
  assign wr = !o_memory_write_strobe_n;
  assign rd = !o_memory_read_strobe_n;
  a_wr_one_clk: assert property (wr && i_memory_wait_n && i_ce |=> !wr)
    else $error("write strobe too long");
  a_rd_one_clk: assert property (rd && i_memory_wait_n && i_ce |=> !rd)
    else $error("read strobe too long");
  a_wait_stretch: assert property ((wr || rd) && !i_memory_wait_n |=> $stable({wr, rd}))
    else $error("strobe not stretched");
  a_wr_setup: assert property ($fell(o_memory_write_strobe_n)
    |-> $stable(o_mem_addr) && $stable(o_mem_dout))
    else $error("write setup lost");
  a_wr_hold: assert property ($rose(o_memory_write_strobe_n)
    |=> $stable(o_mem_addr) && $stable(o_mem_dout))
    else $error("write hold lost");
  a_rd_setup: assert property ($fell(o_memory_read_strobe_n) |-> $stable(o_mem_addr))
    else $error("read setup lost");
  a_rd_hold: assert property ($rose(o_memory_read_strobe_n) |=> $stable(o_mem_addr))
    else $error("read hold lost");
  a_grant_first: assert property ((wr || rd) |-> !i_memory_bus_grant_n)
    else $error("strobe without grant");
  a_req_kept: assert property (!o_memory_bus_request_n && i_memory_bus_grant_n && i_ce
    |=> !o_memory_bus_request_n)
    else $error("request dropped early");
  a_wr_lower: assert property (wr |-> !o_mem_addr[10] && o_mem_dout_en)
    else $error("write outside lower half");
  a_type_used: assert property ((wr || rd) |-> o_memory_access_type != 2'b11)
    else $error("unused access type");
  a_status_area: assert property (wr && o_memory_access_type == 2'b01
    |-> o_mem_addr[9:5] inside {5'h00, 5'h1f})
    else $error("status word misplaced");
endmodule : rtbm_checker

bind rtbm_backend rtbm_checker #(.RTRT_CYC(RTRT_CYC)) rtbm_checker_i (.i_clk, .i_rst_n,
  .i_ce, .i_memory_bus_grant_n, .i_memory_wait_n, .o_memory_bus_request_n,
  .o_memory_write_strobe_n, .o_memory_read_strobe_n, .o_memory_access_type,
  .o_mem_addr, .o_mem_dout, .o_mem_dout_en);

// ### verification/rtbm_mem_model.sv
// Buffer memory and bus arbiter beside the backend engine
`timescale 1ns/10ps
module rtbm_mem_model
  import rtbm_pkg::*;
(
  // Clock and bus
  input  wire logic        i_clk,
  input  wire logic        i_req_n,
  input  wire logic        i_wr_n,
  input  wire logic        i_rd_n,
  input  wire logic [10:0] i_addr,
  input  wire logic [15:0] i_dout,
  // Answer speed set by the bench
  input  wire logic [31:0] i_gnt_dly,
  input  wire logic [31:0] i_wait_cyc,
  // Answers
  output logic             o_grant_n,
  output logic             o_wait_n,
  output logic [15:0]      o_din
);
  rtbm_data_t mem [2048];
  rtbm_data_t last = 16'h0000;
  int gcnt = 0;
  int wcnt = 0;
  // Known pattern so reads can be predicted
  initial
    for (int i = 0; i < 2048; i++)
      mem[i] = 16'(i) ^ 16'hc3c3;
  // Grant and wait counters, write capture when the strobe ends
  always @(posedge i_clk)
  begin
    gcnt <= i_req_n ? 0 : gcnt + 1;
    wcnt <= (i_wr_n && i_rd_n) ? 0 : wcnt + 1;
    if (!i_wr_n && o_wait_n)
      mem[i_addr] <= i_dout;
    if (!i_rd_n)
      last <= o_din;
  end
  // Grant after a short delay, far under the allowed limit
  assign o_grant_n = !(!i_req_n && gcnt >= i_gnt_dly);
  assign o_wait_n = !(!(i_wr_n && i_rd_n) && wcnt < i_wait_cyc);
  // Released data lines show the inverse of the last word
  assign o_din = i_rd_n ? ~last : mem[i_addr];
endmodule : rtbm_mem_model

// ### verification/tb.sv
// Self-checking bench for the backend memory engine
`timescale 1ns/10ps
module tb;
  import rtbm_pkg::*;
  localparam int RT = 40;
  logic clk = 1'b0, rst_n = 1'b0, ce = 1'b1, valid = 1'b0, wr = 1'b0, tx = 1'b0;
  logic loop = 1'b0, par = 1'b0, srdy = 1'b0, rstart = 1'b0, dsync = 1'b0;
  logic sent = 1'b0, evalid = 1'b0;
  logic [1:0] typ = 2'b00;
  logic [4:0] sa = 5'h00, wd = 5'h00;
  rtbm_data_t wdata = 16'h0000, txw = 16'h0000, ecw = 16'h0000;
  wire logic ready, done, err, req_n, gnt_n, wait_n, wr_n, rd_n, den, go, miss, rto, eerr;
  wire logic [1:0] mtype;
  wire logic [10:0] addr;
  wire logic [15:0] rdata, dout, din;
  int gdly = 0, wcyc = 0, failures = 0, comparisons = 0, strobes = 0;

  rtbm_backend #(.RTRT_CYC(RT)) rtbm_backend_i (.i_clk(clk), .i_rst_n(rst_n), .i_ce(ce),
    .i_acc_valid(valid), .o_acc_ready(ready), .i_acc_write(wr), .i_acc_type(typ),
    .i_acc_tx(tx), .i_acc_sa(sa), .i_acc_word(wd), .i_acc_wdata(wdata), .o_acc_done(done),
    .o_acc_error(err), .o_acc_rdata(rdata), .i_subaddr_thirty_loopback(loop),
    .o_memory_bus_request_n(req_n), .i_memory_bus_grant_n(gnt_n), .i_memory_wait_n(wait_n),
    .o_memory_write_strobe_n(wr_n), .o_memory_read_strobe_n(rd_n),
    .o_memory_access_type(mtype), .o_mem_addr(addr), .o_mem_dout(dout),
    .o_mem_dout_en(den), .i_mem_din(din), .i_cmd_parity_mid(par), .i_status_ready(srdy),
    .o_status_go(go), .o_resp_miss(miss), .i_rtrt_start(rstart), .i_data_sync(dsync),
    .o_rtrt_timeout(rto), .i_tx_word_sent(sent), .i_tx_word(txw), .i_echo_valid(evalid),
    .i_echo_word(ecw), .o_echo_error(eerr));
  rtbm_mem_model rtbm_mem_model_i (.i_clk(clk), .i_req_n(req_n), .i_wr_n(wr_n),
    .i_rd_n(rd_n), .i_addr(addr), .i_dout(dout), .i_gnt_dly(gdly), .i_wait_cyc(wcyc),
    .o_grant_n(gnt_n), .o_wait_n(wait_n), .o_din(din));

  // Clock and strobe counter
  always #2.5 clk = ~clk;
  always @(negedge wr_n or negedge rd_n) strobes++;

  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      failures++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic stop_test;
    if (failures == 0 && comparisons > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : stop_test

  // One access; bad means a refusal is expected
  task automatic acc(input logic w, input logic [1:0] t, input logic x, input logic [4:0] s,
                     input logic [4:0] k, input logic bad, input logic [10:0] ea);
    int n;
    int st;
    st = strobes;
    @(negedge clk);
    {valid, wr, typ, tx, sa, wd, wdata} = {1'b1, w, t, x, s, k, 5'h15, ea};
    @(negedge clk);
    valid = 1'b0;
    n = 0;
    while (done !== 1'b1 && err !== 1'b1 && n < 300)
    begin
      @(negedge clk);
      n++;
    end
    if (n >= 300)
    begin
      failures++;
      stop_test();
    end
    check("error", err, bad);
    if (bad)
      check("strobes", 16'(strobes - st), 16'h0000);
    else
    begin
      check("address", addr, ea);
      check("type", mtype, t);
      if (w)
        check("stored", rtbm_mem_model_i.mem[ea], {5'h15, ea});
      else
        check("read", rdata, ea ^ 16'hc3c3);
    end
  endtask : acc

  // Cycles from the edge taking a start pulse to an output pulse: 0 go, 1 miss, 2 timeout, 3 echo
  task automatic count_to(input int which, input int lim, output int n);
    logic [3:0] s;
    n = -1;
    do
    begin
      @(negedge clk);
      {par, rstart, sent, evalid, dsync} = 5'h00;
      n++;
      s = {eerr, rto, miss, go};
    end
    while (s[which] !== 1'b1 && n <= lim);
  endtask : count_to

  task automatic s_reset;
    check("idle", {req_n, wr_n, rd_n, den, ready, mtype}, 16'h0074);
    check("idle addr", addr, 16'h0000);
  endtask : s_reset

  task automatic s_mem;
    acc(1, 2'b00, 0, 5'h01, 5'h00, 0, 11'h020);
    gdly = 3;
    wcyc = 2;
    acc(1, 2'b00, 0, 5'h1e, 5'h1f, 0, 11'h3df);
    acc(1, 2'b01, 0, 5'h05, 5'h00, 0, 11'h005);
    acc(1, 2'b01, 1, 5'h14, 5'h00, 0, 11'h3f4);
    acc(1, 2'b10, 1, 5'h03, 5'h00, 0, 11'h3e3);
    wcyc = 1;
    acc(0, 2'b00, 1, 5'h01, 5'h00, 0, 11'h420);
    acc(0, 2'b00, 1, 5'h1e, 5'h1f, 0, 11'h7df);
    gdly = 0;
    wcyc = 0;
    acc(1, 2'b00, 1, 5'h01, 5'h00, 1, 11'h000);
    acc(0, 2'b00, 0, 5'h01, 5'h00, 1, 11'h000);
    acc(1, 2'b11, 0, 5'h01, 5'h00, 1, 11'h000);
  endtask : s_mem

  task automatic s_loop;
    loop = 1'b1;
    repeat (3) @(negedge clk);
    acc(0, 2'b00, 1, 5'h1e, 5'h02, 0, 11'h3c2);
    acc(1, 2'b01, 1, 5'h1e, 5'h00, 0, 11'h3fe);
    loop = 1'b0;
    repeat (3) @(negedge clk);
    acc(0, 2'b00, 1, 5'h1e, 5'h02, 0, 11'h7c2);
  endtask : s_loop

  task automatic s_timers;
    int n;
    srdy = 1'b1;
    par = 1'b1;
    count_to(0, 2000, n);
    check("status go", 16'(n), 16'd950);
    srdy = 1'b0;
    par = 1'b1;
    count_to(1, 2000, n);
    check("resp miss", 16'(n), 16'd1400);
    rstart = 1'b1;
    count_to(2, 100, n);
    check("rtrt timeout", 16'(n), 16'(RT));
    rstart = 1'b1;
    count_to(2, 10, n);
    dsync = 1'b1;
    count_to(2, 100, n);
    check("rtrt synced", 16'(n), 16'd101);
    {sent, txw} = {1'b1, 16'h5a3c};
    count_to(3, 10, n);
    {evalid, ecw} = {1'b1, 16'h5a3c};
    count_to(3, 500, n);
    check("echo good", 16'(n), 16'd501);
    sent = 1'b1;
    count_to(3, 2, n);
    {evalid, ecw} = {1'b1, 16'h5a3d};
    count_to(3, 5, n);
    check("echo bad", 16'(n), 16'h0000);
    sent = 1'b1;
    count_to(3, 600, n);
    check("echo late", 16'(n), 16'd460);
  endtask : s_timers

  // Main sequence
  initial
  begin
    repeat (4) @(negedge clk);
    rst_n = 1'b1;
    s_reset();
    s_mem();
    s_loop();
    s_timers();
    stop_test();
  end
endmodule : tb
